// ### timer_defs.svh
// Constants for the basic interval timer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every design file that needs it.
// Functional notes
// RQ1: Eight-bit up counter; wraps FF to 00, keeps counting, sets request flag.
// RQ2: Mode bit seven stops the timer when clear, runs it when set.
// RQ3: Bits six to four select CPU clock divide 256 down to 2.
// RQ4: Mode bit zero set gives half-second real-time ticks from 32768 Hz.
// RQ5: Mode bit zero clear counts the prescaled CPU clock.
// RQ6: Prescale field has no effect in real-time mode.
// RQ7: Count value does not set the real-time interval; fixed half second.
// RQ8: Enabled timer time-out wakes the system from green mode.
// RQ9: Mode bit one enables green wake of first timer/counter.
// RQ10: Mode bit two picks fast oscillator source for first timer/counter.
// RQ11: Mode bit three picks fast oscillator source for second one.
// RQ12: Software loads count with 256 minus interval times clock rate.
// RQ13: Software stops, clears flags, configures, loads, enables, then starts.
// RQ14: Shared-vector service tests each enable bit and request flag.
// RQ15: Enabled counter steps per tick; count writes act at once.
// RQ16: Request flag sticks until cleared; interrupt only while enabled.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define OFS_MODE        8'hD8
`define OFS_COUNT       8'hD9
`define OFS_IRQ_CTRL    8'hDC
`define OFS_IRQ_STATUS  8'hDD
`define OFS_IRQ_MASK    8'hDE

`define BIT_RUN         7
`define BIT_RATE_HI     6
`define BIT_RATE_LO     4
`define BIT_TCB_FAST    3
`define BIT_TCA_FAST    2
`define BIT_TCA_GREEN   1
`define BIT_RTC_SEL     0

`define BIT_IRQ_EN      0
`define BIT_IRQ_FLAG    1

`define RST_BYTE        8'h00
`define CPU_HZ          10000000
`define RTC_HZ          32768
`define RTC_PERIOD_MS   500
`define RTC_TICKS_PER_PERIOD ((`RTC_HZ * `RTC_PERIOD_MS) / 1000)

`endif

// ### timer_pkg.sv
// Types shared by the basic interval timer files.
// Assumes nothing of its surroundings.
package timer_pkg;
    typedef struct packed {
        logic       run;
        logic [2:0] rate;
        logic       tcb_fast;
        logic       tca_fast;
        logic       tca_green;
        logic       rtc_sel;
    } mode_type;

    typedef struct packed {
        logic [7:0] address;
        logic       read;
        logic       write;
        logic [7:0] writedata;
    } bus_req_type;
endpackage

// ### rtc_sync.sv
// Two-flop synchroniser plus rising-edge detector for the 32768 Hz clock.
// Assumes the low-speed clock is asynchronous to clk.
`timescale 1ns/1ps
module rtc_sync (
    input  wire logic clk,        // CPU-side clock
    input  wire logic rst,        // Asynchronous reset, high
    input  wire logic lclk_pin,   // Low-speed crystal clock
    output logic      lclk_rise   // One pulse per low-speed rising edge
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= lclk_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign lclk_rise = s2_r & ~s3_r;
endmodule // rtc_sync

// ### tick_gen.sv
// Tick source: CPU prescaler or half-second real-time divider.
// Assumes lclk_rise is already synchronised to clk.
`timescale 1ns/1ps
`include "timer_defs.svh"
module tick_gen #(
    parameter int RTC_COUNT = `RTC_TICKS_PER_PERIOD
) (
    input  wire logic       clk,       // CPU clock
    input  wire logic       rst,       // Asynchronous reset, high
    input  wire logic       run,       // Timer running
    input  wire logic       rtc_sel,   // Real-time source chosen
    input  wire logic [2:0] rate,      // Prescale code
    input  wire logic       lclk_rise, // Low-speed clock edge
    output logic            tick       // One-cycle counting tick
);
    logic [7:0]  pre_r;
    logic [15:0] rtc_r;
    logic [7:0]  pre_mask;
    logic        pre_tick;
    logic        rtc_tick;

    // Code 0 divides by 256, code 7 by 2
    assign pre_mask = 8'hFF >> rate; // RQ3
    assign pre_tick = ((pre_r & pre_mask) == pre_mask);
    assign rtc_tick = lclk_rise && (rtc_r == 16'(RTC_COUNT - 1)); // RQ7
    assign tick = run && (rtc_sel ? rtc_tick : pre_tick); // RQ4 RQ5 RQ6

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r <= 8'h00;
            rtc_r <= 16'h0000;
        end else if (!run) begin
            pre_r <= 8'h00;
            rtc_r <= 16'h0000;
        end else begin
            pre_r <= pre_r + 8'h01;
            if (lclk_rise)
                rtc_r <= rtc_tick ? 16'h0000 : rtc_r + 16'h0001;
        end
    end
endmodule // tick_gen

// ### interval_timer.sv
// Basic interval timer with Avalon-MM register slave and interrupt logic.
// Assumes a synchronous Avalon master on clk and a free 32768 Hz crystal.
`timescale 1ns/1ps
`include "timer_defs.svh"
module interval_timer #(
    parameter int RTC_COUNT = `RTC_TICKS_PER_PERIOD
) (
    input  wire logic       clk,          // CPU clock, 10 MHz
    input  wire logic       rst,          // Asynchronous reset, high
    input  wire logic [7:0] address,      // Avalon byte address
    input  wire logic       read,         // Avalon read
    input  wire logic       write,        // Avalon write
    input  wire logic [31:0] writedata,   // Avalon write data
    output logic [31:0]     readdata,     // Avalon read data
    output logic            waitrequest,  // Avalon stall
    input  wire logic       lclk_pin,     // Low-speed crystal clock
    input  wire logic       green_mode,   // System in green mode
    output logic            wake,         // Green-mode wake pulse
    output logic            tca_green_en, // First timer/counter wake enable
    output logic            tca_fast,     // First timer/counter fast source
    output logic            tcb_fast,     // Second timer/counter fast source
    output logic            irq           // Level interrupt
);
    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    timer_pkg::mode_type    mode_r;
    timer_pkg::bus_req_type req;
    logic [7:0]  count_r;
    logic [7:0]  count_nxt;
    logic        irq_en_r;
    logic        irq_flag_r;
    logic        irq_flag_nxt;
    logic        status_r;
    logic        status_nxt;
    logic        mask_r;
    logic        ack_r;
    logic        wake_r;
    logic [31:0] rdata_r;
    logic        lclk_rise;
    logic        tick;
    logic        overflow;
    logic        wr_mode;
    logic        wr_count;
    logic        wr_ctrl;
    logic        wr_mask;
    logic        rd_status;
    logic        access;
    logic [7:0]  rd_mux;

    assign req = '{address: address, read: read, write: write,
                   writedata: writedata[7:0]};

    //------------------------------------------------------------
    // Tick sources
    //------------------------------------------------------------
    rtc_sync u_sync (
        .clk       (clk),
        .rst       (rst),
        .lclk_pin  (lclk_pin),
        .lclk_rise (lclk_rise)
    );

    tick_gen #(.RTC_COUNT(RTC_COUNT)) u_tick (
        .clk       (clk),
        .rst       (rst),
        .run       (mode_r.run),
        .rtc_sel   (mode_r.rtc_sel),
        .rate      (mode_r.rate),
        .lclk_rise (lclk_rise),
        .tick      (tick)
    );

    //------------------------------------------------------------
    // Bus decode: one wait cycle, answer on the second edge
    //------------------------------------------------------------
    assign access      = (req.read || req.write) && !ack_r;
    assign waitrequest = (req.read || req.write) && !ack_r;
    assign wr_mode   = req.write && ack_r && req.address == `OFS_MODE;
    assign wr_count  = req.write && ack_r && req.address == `OFS_COUNT;
    assign wr_ctrl   = req.write && ack_r && req.address == `OFS_IRQ_CTRL;
    assign wr_mask   = req.write && ack_r && req.address == `OFS_IRQ_MASK;
    assign rd_status = req.read && ack_r && req.address == `OFS_IRQ_STATUS;
    assign readdata  = rdata_r;

    assign rd_mux =
        (req.address == `OFS_MODE)       ? mode_r :
        (req.address == `OFS_COUNT)      ? count_r :
        (req.address == `OFS_IRQ_CTRL)   ? {6'h00, irq_flag_r, irq_en_r} :
        (req.address == `OFS_IRQ_STATUS) ? {7'h00, status_r} :
        (req.address == `OFS_IRQ_MASK)   ? {7'h00, mask_r} : 8'h00;

    //------------------------------------------------------------
    // Counter and flags
    //------------------------------------------------------------
    // In real-time mode every half-second tick is a time-out, whatever
    // the count holds; otherwise only the wrap from FF to 00 is one
    assign overflow  = tick && (mode_r.rtc_sel || count_r == 8'hFF); // RQ1 RQ7
    assign count_nxt = wr_count ? req.writedata :               // RQ15
                       tick ? count_r + 8'h01 : count_r;         // RQ15
    // Overflow wins over a software clear in the same cycle
    assign irq_flag_nxt = overflow ? 1'b1 :                      // RQ16
                          wr_ctrl ? req.writedata[`BIT_IRQ_FLAG] :
                          irq_flag_r;
    assign status_nxt = overflow ? 1'b1 : rd_status ? 1'b0 : status_r;

    assign irq = (irq_en_r && irq_flag_r) || (mask_r && status_r); // RQ16
    assign wake = wake_r;
    assign tca_green_en = mode_r.tca_green; // RQ9
    assign tca_fast = mode_r.tca_fast;      // RQ10
    assign tcb_fast = mode_r.tcb_fast;      // RQ11

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r     <= `RST_BYTE;
            count_r    <= `RST_BYTE;
            irq_en_r   <= 1'b0;
            irq_flag_r <= 1'b0;
            status_r   <= 1'b0;
            mask_r     <= 1'b0;
            ack_r      <= 1'b0;
            wake_r     <= 1'b0;
            rdata_r    <= 32'h0000_0000;
        end else begin
            ack_r      <= access;
            count_r    <= count_nxt;
            irq_flag_r <= irq_flag_nxt;
            status_r   <= status_nxt;
            wake_r     <= overflow && green_mode; // RQ8
            if (wr_mode)
                mode_r <= req.writedata; // RQ2
            if (wr_ctrl)
                irq_en_r <= req.writedata[`BIT_IRQ_EN];
            if (wr_mask)
                mask_r <= req.writedata[0];
            if (access && req.read)
                rdata_r <= {24'h000000, rd_mux};
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    a_wrap_sets_flag: assert property (@(posedge clk) // RQ1
        disable iff (rst)
        tick && count_r == 8'hFF && !wr_count
        |=> irq_flag_r && status_r && count_r == 8'h00)
        else $error("overflow did not set flag");
    a_stopped_holds: assert property (@(posedge clk) // RQ2
        disable iff (rst)
        !mode_r.run && !wr_count |=> $stable(count_r))
        else $error("stopped counter moved");
    a_tick_steps: assert property (@(posedge clk) // RQ15
        disable iff (rst)
        tick && !wr_count |=> count_r == $past(count_r) + 8'h01)
        else $error("counter did not step");
    a_write_count: assert property (@(posedge clk) // RQ15
        disable iff (rst)
        wr_count |=> count_r == $past(req.writedata))
        else $error("count write lost");
    a_fast_rate: assert property (@(posedge clk) // RQ3
        disable iff (rst || wr_mode)
        mode_r.run && !mode_r.rtc_sel && mode_r.rate == 3'h7 && tick
        |=> !tick ##1 tick)
        else $error("divide by two wrong");
    a_rtc_no_cpu: assert property (@(posedge clk) // RQ6
        disable iff (rst)
        mode_r.rtc_sel && !lclk_rise |-> !tick)
        else $error("cpu tick in rtc mode");
    a_rtc_fixed: assert property (@(posedge clk) // RQ7
        disable iff (rst)
        mode_r.rtc_sel && tick |=> status_r && irq_flag_r)
        else $error("rtc tick did not time out");
    a_flag_sticks: assert property (@(posedge clk) // RQ16
        disable iff (rst)
        irq_flag_r && !wr_ctrl |=> irq_flag_r)
        else $error("flag dropped");
    a_wake_pulse: assert property (@(posedge clk) // RQ8
        disable iff (rst)
        overflow && green_mode |=> wake)
        else $error("no wake");
    a_green_bits: assert property (@(posedge clk) // RQ9 RQ10 RQ11
        disable iff (rst)
        wr_mode |=> tca_green_en == $past(req.writedata[`BIT_TCA_GREEN])
        && tca_fast == $past(req.writedata[`BIT_TCA_FAST])
        && tcb_fast == $past(req.writedata[`BIT_TCB_FAST]))
        else $error("neighbour bits wrong");
    a_rtc_select: assert property (@(posedge clk) // RQ2 RQ4
        disable iff (rst)
        tick |-> mode_r.run && (!mode_r.rtc_sel || lclk_rise))
        else $error("rtc source wrong");
    a_cpu_source: assert property (@(posedge clk) // RQ5
        disable iff (rst)
        mode_r.run && !mode_r.rtc_sel && u_tick.pre_r == 8'hFF |-> tick)
        else $error("cpu prescaler tick missing");
    a_wait_one: assert property (@(posedge clk)
        disable iff (rst)
        access |=> !waitrequest)
        else $error("bus answer late");

    c_overflow: cover property (@(posedge clk) overflow);
    c_rtc_tick: cover property (@(posedge clk) mode_r.rtc_sel && tick);
    c_wake:     cover property (@(posedge clk) wake);
endmodule // interval_timer

// ### tb.sv
// Self-checking bench for the basic interval timer and its register slave.
// Assumes the design files and timer_defs.svh are compiled before it.
`timescale 1ns/1ps
`include "timer_defs.svh"
module tb;
    localparam int RTC_N = 4;
    localparam int RTC_T = RTC_N * 305;
    localparam int LIMIT = 60000;
    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic [7:0]  address     = 8'h00;
    logic        read        = 1'b0;
    logic        write       = 1'b0;
    logic [31:0] writedata   = 32'h0;
    logic        lclk_pin    = 1'b0;
    logic        green_mode  = 1'b0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        wake;
    logic        tca_green_en;
    logic        tca_fast;
    logic        tcb_fast;
    logic        irq;
    logic [31:0] exp_q[$];
    logic [7:0]  d;
    logic [7:0]  regs[5] = '{8'hD8, 8'hD9, 8'hDC, 8'hDD, 8'hDE};
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          wake_cnt = 0;
    int          seed = 24;
    int          div;

    always #50 clk = ~clk;
    // Free-running 32768 Hz crystal
    always #15259 lclk_pin = ~lclk_pin;

    interval_timer #(.RTC_COUNT(RTC_N)) i_dut (
        .clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .lclk_pin(lclk_pin),
        .green_mode(green_mode), .wake(wake),
        .tca_green_en(tca_green_en), .tca_fast(tca_fast),
        .tcb_fast(tcb_fast), .irq(irq)
    );

    //------------------------------------------------------------
    // Checking and closing
    //------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    //------------------------------------------------------------
    // Bus master
    //------------------------------------------------------------
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        address <= a;
        writedata <= {24'h000000, v};
        write <= 1'b1;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] v);
        exp_q.push_back({24'h000000, v});
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        read <= 1'b0;
    endtask

    task automatic wait_irq(input int lo, input int hi);
        int n;
        n = 0;
        while (irq !== 1'b1 && n <= hi) begin
            @(negedge clk);
            n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask

    //------------------------------------------------------------
    // Output watcher and timeout
    //------------------------------------------------------------
    always @(negedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            check(readdata, exp_q.pop_front());
        end
        if (wake === 1'b1) begin
            wake_cnt++;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            report_and_stop();
        end
    end

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) bus_rd(regs[i], 8'h00);
        bus_wr(8'hDA, 8'hFF);
        bus_rd(8'hDA, 8'h00);
        bus_wr(`OFS_MODE, 8'h0E);
        @(negedge clk);
        check({29'h0, tcb_fast, tca_fast, tca_green_en}, 32'h7);
        bus_rd(`OFS_MODE, 8'h0E);
        d = 8'($random(seed));
        bus_wr(`OFS_COUNT, d);
        repeat (20) @(posedge clk);
        bus_rd(`OFS_COUNT, d);
        for (int c = 0; c < 8; c++) begin
            green_mode <= c[0];
            bus_wr(`OFS_MODE, 8'h00);
            bus_wr(`OFS_IRQ_CTRL, 8'h00);
            bus_wr(`OFS_COUNT, 8'hF0);
            bus_wr(`OFS_IRQ_CTRL, 8'h01);
            wake_cnt = 0;
            bus_wr(`OFS_MODE, {1'b1, c[2:0], 4'h0});
            div = 256 >> c;
            wait_irq(15 * div, 17 * div + 8);
            bus_wr(`OFS_MODE, 8'h00);
            check(32'(wake_cnt), 32'(c[0]));
            bus_rd(`OFS_IRQ_CTRL, 8'h03);
            bus_rd(`OFS_IRQ_STATUS, 8'h01);
            bus_rd(`OFS_IRQ_STATUS, 8'h00);
        end
        green_mode <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            bus_wr(`OFS_IRQ_CTRL, 8'h00);
            bus_wr(`OFS_IRQ_MASK, 8'h01);
            d = 8'($random(seed));
            bus_wr(`OFS_COUNT, d);
            bus_wr(`OFS_MODE, {1'b1, d[6:4], 4'h1});
            wait_irq(RTC_T - 320, RTC_T + 320);
            bus_wr(`OFS_MODE, 8'h00);
            bus_rd(`OFS_IRQ_CTRL, 8'h02);
            bus_rd(`OFS_IRQ_STATUS, 8'h01);
            repeat (2) @(negedge clk);
            check({31'h0, irq}, 32'h0);
        end
        bus_wr(`OFS_IRQ_MASK, 8'h00);
        report_and_stop();
    end
endmodule // tb
